// File: src/bms_boot_sequencer.sv
`default_nettype none
module bms_boot_sequencer
  import bms_pkg::*;
#(
  parameter bit HAS_HOST_PORT = 1'b1,
  parameter int BOOT_BYTES = BMS_BOOT_BYTES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Boot mode straps from pins
  input wire logic [1:0] boot_mode_pins,
  // Host port side
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_wdata,
  output logic host_ack,
  input wire logic host_to_cpu_interrupt_bit,
  // CPU side
  input wire logic cpu_clear_interrupt,
  output logic cpu_stall,
  output logic cpu_reset_n,
  output logic [31:0] cpu_start_addr,
  output logic cpu_int_pending,
  output logic periph_reset_n,
  // Boot ROM in chip-enable space 1
  output logic [31:0] rom_addr,
  output logic rom_rd,
  input wire logic [7:0] rom_data,
  input wire logic rom_valid,
  // Memory port for host reads and writes and the boot copy, decoded to internal RAM or external spaces
  output bms_mem_req_type mem,
  input wire logic mem_ack,
  output logic mem_ram_sel,
  output logic mem_ext_sel,
  output logic [1:0] mem_ce,
  // Status
  output bms_mode_type boot_mode,
  output logic boot_done
);
  typedef enum logic [2:0] {SQ_RESET, SQ_CAPTURE, SQ_HOST, SQ_COPY, SQ_RUN} bms_sq_state_type;
  bms_sq_state_type state;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic int_meta;
  logic int_sync;
  logic int_prev;
  logic int_blocked;
  logic copy_start;
  logic copy_done;
  bms_mem_req_type copy_wr;
  bms_mode_type next_mode;

  wire logic int_rise = int_sync && !int_prev;
  always_comb
  begin
    unique case (pin_sync)
      2'h1: next_mode = HAS_HOST_PORT ? BMS_MODE_HOST : BMS_MODE_NONE;
      2'h2: next_mode = BMS_MODE_EXT;
      default: next_mode = BMS_MODE_NONE;
    endcase
  end

  wire logic host_path = (state == SQ_HOST) || (state == SQ_RUN && boot_mode == BMS_MODE_HOST);
  wire bms_mem_req_type host_mem = '{req: host_req, we: host_we, addr: host_addr,
                                     wdata: host_wdata};
  assign mem = (state == SQ_COPY) ? copy_wr : (host_path ? host_mem : '0);
  assign host_ack = host_path && mem_ack;
  wire bms_decode_type dec = bms_decode(mem.addr);
  assign mem_ram_sel = dec.ram_sel;
  assign mem_ext_sel = dec.ext_sel;
  assign mem_ce = dec.ce;

  assign periph_reset_n = (state != SQ_RESET) && (state != SQ_CAPTURE);
  assign cpu_reset_n = periph_reset_n;
  assign cpu_stall = (state != SQ_RUN);
  assign cpu_start_addr = BMS_BOOT_DEST;
  assign boot_done = (state == SQ_RUN);
  assign copy_start = (state == SQ_COPY);

  // The strap synchroniser keeps running through reset, so the capture sees settled pins.
  always_ff @(posedge clk)
  begin
    pin_meta <= boot_mode_pins;
    pin_sync <= pin_meta;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_meta <= 1'b0;
      int_sync <= 1'b0;
      int_prev <= 1'b0;
    end
    else
    begin
      int_meta <= host_to_cpu_interrupt_bit;
      int_sync <= int_meta;
      int_prev <= int_sync;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= SQ_RESET;
      boot_mode <= BMS_MODE_NONE;
    end
    else
    begin
      unique case (state)
        SQ_RESET:
          state <= SQ_CAPTURE;
        SQ_CAPTURE:
        begin
          boot_mode <= next_mode;
          unique case (next_mode)
            BMS_MODE_HOST: state <= SQ_HOST;
            BMS_MODE_EXT: state <= SQ_COPY;
            default: state <= SQ_RUN;
          endcase
        end
        SQ_HOST:
          if (int_rise)
            state <= SQ_RUN;
        SQ_COPY:
          if (copy_done)
            state <= SQ_RUN;
        SQ_RUN:
          state <= SQ_RUN;
        default:
          state <= SQ_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_blocked <= 1'b0;
      cpu_int_pending <= 1'b0;
    end
    else
    begin
      if (state == SQ_HOST && int_rise)
        int_blocked <= 1'b1;
      else if (state == SQ_RUN && int_rise && !int_blocked)
        int_blocked <= 1'b1;
      else if (cpu_clear_interrupt)
        int_blocked <= 1'b0;
      if (state == SQ_RUN && int_rise && !int_blocked)
        cpu_int_pending <= 1'b1;
      else if (cpu_clear_interrupt)
        cpu_int_pending <= 1'b0;
    end
  end

  bms_rom_packer #(
    .WORDS(BOOT_BYTES / BMS_BYTES_PER_WORD)
  ) u_packer (
    .clk(clk),
    .nrst(nrst),
    .start(copy_start),
    .done(copy_done),
    .rom_addr(rom_addr),
    .rom_rd(rom_rd),
    .rom_data(rom_data),
    .rom_valid(rom_valid),
    .wr(copy_wr),
    .wr_ack(mem_ack)
  );

  AST_STALL_UNTIL_RUN: assert property (@(posedge clk) disable iff (!nrst)
    $fell(cpu_stall) |-> (boot_mode == BMS_MODE_NONE) ||
      (boot_mode == BMS_MODE_HOST && $past(int_rise)) ||
      (boot_mode == BMS_MODE_EXT && $past(copy_done)))
    else $error("CPU left stall before boot finished.");
  AST_HOST_PERIPH: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_HOST |-> cpu_stall && periph_reset_n && cpu_reset_n)
    else $error("Host boot did not release peripherals with CPU stalled.");
  AST_HOST_PASS: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_HOST && host_req |-> mem.req && mem.addr == host_addr)
    else $error("Host request not passed to memory.");
  AST_RESET_OUTPUTS: assert property (@(posedge clk) disable iff (!nrst)
    !periph_reset_n |-> cpu_stall && !mem.req && !cpu_int_pending && !boot_done)
    else $error("Outputs left reset state too early.");
  AST_COPY_STALL: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_COPY && !copy_done |=> cpu_stall)
    else $error("CPU released during boot copy.");
  AST_HOST_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_HOST && int_rise |=> !cpu_stall)
    else $error("Host interrupt did not release stall.");
  AST_HOST_ONLY: assert property (@(posedge clk) disable iff (!nrst)
    $rose(boot_done) && $past(state) == SQ_HOST |-> boot_mode == BMS_MODE_HOST)
    else $error("Stall released by interrupt outside host boot.");
  AST_NO_LATCH: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_HOST |=> !cpu_int_pending)
    else $error("Boot interrupt latched as pending.");
  AST_BLOCKED: assert property (@(posedge clk) disable iff (!nrst)
    int_blocked && !cpu_clear_interrupt |=> !$rose(cpu_int_pending))
    else $error("Interrupt accepted before CPU cleared bit.");
  AST_MODE_HELD: assert property (@(posedge clk) disable iff (!nrst)
    state != SQ_CAPTURE && state != SQ_RESET |=> $stable(boot_mode))
    else $error("Boot mode changed after capture.");
  AST_NO_HOST_VARIANT: assert property (@(posedge clk) disable iff (!nrst)
    !HAS_HOST_PORT |-> boot_mode != BMS_MODE_HOST)
    else $error("Host boot on variant without host port.");
  AST_COPY_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_COPY && copy_done |=> boot_done && !cpu_stall)
    else $error("Copy completion did not release CPU.");
  AST_START_SEQ: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_RESET |=> state == SQ_CAPTURE ##1 periph_reset_n)
    else $error("Release sequence out of order.");
  AST_COPY_DEST: assert property (@(posedge clk) disable iff (!nrst)
    state == SQ_COPY && mem.req |-> mem_ram_sel)
    else $error("Boot copy written outside internal RAM.");
endmodule : bms_boot_sequencer
`default_nettype wire

// File: pkg/bms_pkg.sv
// Overview of operation
// - Reset low holds everything but the strap synchroniser in reset state.
// - Reset release starts selected configuration and boot.
// - Host boot stalls CPU, releases rest.
// - Host reads and writes all memory.
// - Host interrupt bit ends host boot.
// - Boot-ending interrupt never latched as pending.
// - Interrupt releases stall only in host boot.
// - No new interrupt until CPU clears bit.
// - Reduced variant offers no host boot.
// - External boot copies 1K bytes from space 1.
// - Four ROM bytes packed per 32-bit word.
// - Copy is one automatic block transfer.
// - Copy done releases CPU at address 0.
// - No boot executes directly from address 0.
// - Internal RAM decoded at 0, 128K bytes.
// - External spaces from 0x80000000, 256M each.
`default_nettype none
package bms_pkg;
  localparam logic [31:0] BMS_RAM_BASE = 32'h0000_0000;
  localparam logic [31:0] BMS_RAM_LAST = 32'h0001_ffff;
  localparam logic [31:0] BMS_EXT_BASE = 32'h8000_0000;
  localparam logic [31:0] BMS_EXT_LAST = 32'hbfff_ffff;
  localparam int BMS_CE_SHIFT = 28;
  localparam logic [1:0] BMS_SPACE1 = 2'h1;
  localparam logic [31:0] BMS_SPACE1_BASE = 32'h9000_0000;
  localparam logic [31:0] BMS_BOOT_DEST = 32'h0000_0000;
  localparam int BMS_BOOT_BYTES = 1024;
  localparam int BMS_BYTES_PER_WORD = 4;
  localparam logic [2:0] BMS_ROM_WAIT = 3'h3;

  typedef enum logic [1:0] {
    BMS_MODE_NONE = 2'h0,
    BMS_MODE_HOST = 2'h1,
    BMS_MODE_EXT = 2'h2
  } bms_mode_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bms_mem_req_type;

  typedef struct packed {
    logic ram_sel;
    logic ext_sel;
    logic [1:0] ce;
  } bms_decode_type;

  function automatic bms_decode_type bms_decode(input logic [31:0] a);
    bms_decode_type d;
    d.ram_sel = (a >= BMS_RAM_BASE) && (a <= BMS_RAM_LAST);
    d.ext_sel = (a >= BMS_EXT_BASE) && (a <= BMS_EXT_LAST);
    d.ce = a[BMS_CE_SHIFT+1:BMS_CE_SHIFT];
    return d;
  endfunction : bms_decode
endpackage : bms_pkg
`default_nettype wire

// File: src/bms_rom_packer.sv
`default_nettype none
module bms_rom_packer
  import bms_pkg::*;
#(
  parameter int WORDS = BMS_BOOT_BYTES / BMS_BYTES_PER_WORD
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  output logic done,
  // Byte ROM side
  output logic [31:0] rom_addr,
  output logic rom_rd,
  input wire logic [7:0] rom_data,
  input wire logic rom_valid,
  // Word write side
  output bms_mem_req_type wr,
  input wire logic wr_ack
);
  typedef enum logic [1:0] {PK_IDLE, PK_READ, PK_WRITE, PK_DONE} bms_pk_state_type;
  bms_pk_state_type state;
  logic [$clog2(WORDS)-1:0] word_idx;
  logic [1:0] byte_idx;
  logic [23:0] acc;
  wire logic last_byte = (byte_idx == 2'(BMS_BYTES_PER_WORD - 1));
  wire logic last_word = (word_idx == ($clog2(WORDS))'(WORDS - 1));
  wire logic [31:0] word_bytes = 32'({word_idx, byte_idx});

  assign rom_addr = BMS_SPACE1_BASE + word_bytes;
  assign rom_rd = (state == PK_READ);
  assign done = (state == PK_DONE);

  // byte packing
  // First byte lands in the low lane, matching the system byte order.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= PK_IDLE;
      word_idx <= '0;
      byte_idx <= '0;
      acc <= '0;
      wr <= '0;
    end
    else
    begin
      unique case (state)
        PK_IDLE:
          if (start)
            state <= PK_READ;
        PK_READ:
          if (rom_valid)
          begin
            byte_idx <= byte_idx + 2'h1;
            if (last_byte)
            begin
              wr.req <= 1'b1;
              wr.we <= 1'b1;
              wr.addr <= BMS_BOOT_DEST + {word_bytes[31:2], 2'h0};
              wr.wdata <= {rom_data, acc};
              state <= PK_WRITE;
            end
            else
              acc <= {rom_data, acc[23:8]};
          end
        PK_WRITE:
          if (wr_ack)
          begin
            wr.req <= 1'b0;
            word_idx <= word_idx + 1'b1;
            state <= last_word ? PK_DONE : PK_READ;
          end
        PK_DONE:
          state <= PK_DONE;
      endcase
    end
  end

  AST_WRITE_HOLDS: assert property (@(posedge clk) disable iff (!nrst)
    wr.req && !wr_ack |=> wr.req && $stable(wr.addr) && $stable(wr.wdata))
    else $error("Packed word write dropped before acknowledge.");
endmodule : bms_rom_packer
`default_nettype wire

// File: bench/bms_far_model.sv
`default_nettype none
module bms_far_model
  import bms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Answer pacing
  input wire logic [3:0] delay,
  // Boot ROM side
  input wire logic [31:0] rom_addr,
  input wire logic rom_rd,
  output logic [7:0] rom_data,
  output logic rom_valid,
  // Memory side
  input wire bms_mem_req_type mem,
  output logic mem_ack
);
  logic [3:0] rcnt;
  logic [3:0] mcnt;
  // system byte order
  // Byte n of the image is n plus 10h; an idle data bus shows the inverse of its last value.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rcnt <= 4'h0;
      rom_valid <= 1'b0;
      rom_data <= 8'h00;
    end
    else if (rom_rd && !rom_valid && rcnt >= delay)
    begin
      rcnt <= 4'h0;
      rom_valid <= 1'b1;
      rom_data <= rom_addr[7:0] + 8'h10;
    end
    else
    begin
      rcnt <= (rom_rd && !rom_valid) ? rcnt + 4'h1 : 4'h0;
      rom_valid <= 1'b0;
      rom_data <= ~rom_data;
    end
  end
  // host and boot copy memory access
  // Every memory request is answered after the set delay, one cycle of acknowledge each.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mcnt <= 4'h0;
      mem_ack <= 1'b0;
    end
    else
    begin
      mem_ack <= mem.req && !mem_ack && mcnt >= delay;
      mcnt <= (mem.req && !mem_ack && mcnt < delay) ? mcnt + 4'h1 : 4'h0;
    end
  end
endmodule : bms_far_model
`default_nettype wire

// File: bench/test_boot_mode_sequencer.sv
`default_nettype none
module test_boot_mode_sequencer;
  import bms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NB = 16;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] pins = 2'h0;
  logic host_req = 1'b0;
  logic host_we = 1'b0;
  logic [31:0] host_addr = 32'h0;
  logic [31:0] host_wdata = 32'h0;
  logic irq_bit = 1'b0;
  logic cpu_clr = 1'b0;
  logic [3:0] delay = 4'h0;
  logic host_ack, cpu_stall, cpu_reset_n, cpu_int_pending, periph_reset_n;
  logic [31:0] cpu_start_addr, rom_addr;
  logic rom_rd, rom_valid, mem_ack, mem_ram_sel, mem_ext_sel, boot_done;
  logic [7:0] rom_data;
  logic [1:0] mem_ce;
  bms_mem_req_type mem;
  bms_mode_type boot_mode;
  bms_mode_type red_mode;
  logic red_stall;
  int failures = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  bms_boot_sequencer #(.HAS_HOST_PORT(1'b1), .BOOT_BYTES(NB)) bms_boot_sequencer_i (
    .clk(clk), .nrst(nrst), .boot_mode_pins(pins), .host_req(host_req),
    .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_ack(host_ack), .host_to_cpu_interrupt_bit(irq_bit),
    .cpu_clear_interrupt(cpu_clr), .cpu_stall(cpu_stall), .cpu_reset_n(cpu_reset_n),
    .cpu_start_addr(cpu_start_addr), .cpu_int_pending(cpu_int_pending),
    .periph_reset_n(periph_reset_n), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_data(rom_data), .rom_valid(rom_valid), .mem(mem), .mem_ack(mem_ack),
    .mem_ram_sel(mem_ram_sel), .mem_ext_sel(mem_ext_sel), .mem_ce(mem_ce),
    .boot_mode(boot_mode), .boot_done(boot_done));
  // Reduced variant without a host port, fed the same straps.
  if (1)
  begin : reduced
    bms_boot_sequencer #(.HAS_HOST_PORT(1'b0), .BOOT_BYTES(NB)) bms_boot_sequencer_i (
      .clk(clk), .nrst(nrst), .boot_mode_pins(pins), .host_req(host_req),
      .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_ack(), .host_to_cpu_interrupt_bit(irq_bit),
      .cpu_clear_interrupt(cpu_clr), .cpu_stall(red_stall), .cpu_reset_n(),
      .cpu_start_addr(), .cpu_int_pending(), .periph_reset_n(), .rom_addr(),
      .rom_rd(), .rom_data(rom_data), .rom_valid(rom_valid), .mem(),
      .mem_ack(mem_ack), .mem_ram_sel(), .mem_ext_sel(), .mem_ce(),
      .boot_mode(red_mode), .boot_done());
  end
  bms_far_model bms_far_model_i (
    .clk(clk), .nrst(nrst), .delay(delay), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_data(rom_data), .rom_valid(rom_valid), .mem(mem), .mem_ack(mem_ack));
  task automatic finish_test();
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  task automatic wait_for(ref logic sig, input logic lvl, input int lim, input string what);
    int i;
    for (i = 0; i < lim && sig !== lvl; i++)
      @(negedge clk);
    if (sig !== lvl)
    begin
      chk(sig, lvl, what);
      finish_test();
    end
  endtask : wait_for
  task automatic boot(input logic [1:0] mode);
    @(posedge clk);
    nrst <= 1'b0;
    pins <= mode;
    irq_bit <= 1'b0;
    cycles(3);
    @(negedge clk);
    chk({cpu_stall, cpu_reset_n, periph_reset_n, mem.req, cpu_int_pending}, 5'h10, "reset");
    @(posedge clk);
    nrst <= 1'b1;
    cycles(4);
    @(negedge clk);
  endtask : boot
  task automatic host_xfer(input logic we, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    host_req <= 1'b1;
    host_we <= we;
    host_addr <= a;
    host_wdata <= d;
    @(negedge clk);
    wait_for(host_ack, 1'b1, 20, "host ack");
    chk({mem.we, mem.addr, mem.wdata}, {we, a, d}, "host to memory");
    @(posedge clk);
    host_req <= 1'b0;
  endtask : host_xfer
  task automatic pulse_irq(input logic clr);
    @(posedge clk);
    irq_bit <= 1'b0;
    cpu_clr <= clr;
    @(posedge clk);
    cpu_clr <= 1'b0;
    cycles(2);
    irq_bit <= 1'b1;
    cycles(5);
    @(negedge clk);
  endtask : pulse_irq
  task automatic no_boot(input logic [1:0] mode);
    boot(mode);
    chk(boot_mode, BMS_MODE_NONE, "mode");
    chk({cpu_stall, boot_done, cpu_start_addr}, {2'h1, 32'h0}, "direct run");
    @(posedge clk);
    pins <= 2'h1;
    host_req <= 1'b1;
    cycles(4);
    @(negedge clk);
    chk({host_ack, boot_mode}, {1'b0, BMS_MODE_NONE}, "mode held, host shut");
    @(posedge clk);
    host_req <= 1'b0;
  endtask : no_boot
  task automatic host_boot();
    boot(2'h1);
    chk({boot_mode, cpu_stall, periph_reset_n}, {BMS_MODE_HOST, 2'h3}, "stalled");
    host_xfer(1'b1, 32'h0001_fffc, 32'hcafe_0123);
    host_xfer(1'b0, 32'h0001_fffc, 32'h0);
    @(negedge clk);
    chk({mem_ram_sel, mem_ext_sel}, 2'h2, "ram decode");
    host_xfer(1'b1, 32'h9000_0010, 32'h5a5a_0f0f);
    @(negedge clk);
    chk({mem_ram_sel, mem_ext_sel, mem_ce}, 4'h5, "space 1 decode");
    chk({red_mode, red_stall}, {BMS_MODE_NONE, 1'b0}, "reduced variant");
    cycles(6);
    @(negedge clk);
    chk(cpu_stall, 1'b1, "still stalled");
    irq_bit <= 1'b1;
    wait_for(cpu_stall, 1'b0, 5, "stall release");
    chk({cpu_int_pending, cpu_start_addr}, 33'h0, "no pending");
    pulse_irq(1'b0);
    chk(cpu_int_pending, 1'b0, "blocked until clear");
    pulse_irq(1'b1);
    chk(cpu_int_pending, 1'b1, "accepted after clear");
  endtask : host_boot
  task automatic ext_boot();
    int n;
    delay <= 4'h3;
    boot(2'h2);
    @(posedge clk);
    irq_bit <= 1'b1;
    for (n = 0; n < NB / 4; n++)
    begin
      @(negedge clk);
      chk({rom_addr[31:4], rom_rd, cpu_stall}, {28'h9000_000, 2'h3}, "rom space");
      wait_for(mem_ack, 1'b1, 100, "word write");
      chk(mem.wdata, {8'h13, 8'h12, 8'h11, 8'h10} + {4{8'(4 * n)}}, "word");
      chk({mem.we, mem.addr, mem_ram_sel}, {1'b1, 32'(4 * n), 1'b1}, "dest");
      @(posedge clk);
    end
    @(posedge clk);
    @(negedge clk);
    chk({boot_mode, cpu_stall, boot_done}, {BMS_MODE_EXT, 2'h1}, "copy done");
    delay <= 4'h0;
  endtask : ext_boot
  task automatic irq_in_ext();
    boot(2'h2);
    irq_bit <= 1'b1;
    cycles(6);
    @(negedge clk);
    chk(cpu_stall, 1'b1, "irq ignored outside host boot");
    wait_for(boot_done, 1'b1, 200, "copy finish");
  endtask : irq_in_ext
  initial
  begin
    cycles(3);
    nrst <= 1'b1;
    no_boot(2'h0);
    no_boot(2'h3);
    host_boot();
    ext_boot();
    irq_in_ext();
    finish_test();
  end
endmodule : test_boot_mode_sequencer
`default_nettype wire
